// File: pkg/ars_pkg.sv
package ars_pkg;
    localparam int          ARS_RES_W   = 10;
    localparam int          ARS_CTRL_W  = 8;
    localparam int          ARS_SYNC_W  = 7;
    localparam int          ARS_IDX_CSN = 0;
    localparam int          ARS_IDX_RW  = 1;
    localparam int          ARS_IDX_SCK = 2;
    localparam int          ARS_IDX_DIN = 3;
    localparam int          ARS_IDX_DIO = 4;
    localparam int          ARS_IDX_CVN = 5;
    localparam int          ARS_IDX_TW  = 6;
    localparam logic [6:0]  ARS_SYNC_RST = 7'h23;
    localparam logic [7:0]  ARS_CTRL_RST = 8'h00;
    localparam logic [3:0]  ARS_BIT_RST  = 4'h0;

    typedef enum logic [3:0] {
        ARS_ST_IDLE  = 4'b0001,
        ARS_ST_READ  = 4'b0010,
        ARS_ST_WRITE = 4'b0100,
        ARS_ST_WDONE = 4'b1000
    } ars_state_t;
endpackage : ars_pkg

// File: rtl/ars_port.sv
// Contract
// - five-wire: result out on dout, control in din
// - select rise with chip select low drives msb
// - later bits shift on falling serial clock
// - up to ten bits, msb first
// - five-wire: release dout on cs rise or select fall
// - write captures first eight rising edges only
// - three-wire: shared pin drives msb while select high
// - three-wire: shifting starts at second falling edge
// - three-wire: shared pin released on select fall
// - auto power-down on busy fall while start is low, up on start rise
module ars_port
    import ars_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  three_wire_i,
    input  wire logic                  cs_n_i,
    input  wire logic                  rd_wr_i,
    input  wire logic                  sclk_i,
    input  wire logic                  din_i,
    input  wire logic                  dio_i,
    input  wire logic                  conversion_start_n_i,
    input  wire logic                  busy_i,
    input  wire logic [ARS_RES_W-1:0]  result_i,
    output logic                       dout_o,
    output logic                       dout_oe_o,
    output logic                       dio_o,
    output logic                       dio_oe_o,
    output logic [ARS_CTRL_W-1:0]      ctrl_byte_o,
    output logic                       ctrl_valid_o,
    output logic                       power_down_o
);
    // pin synchronisers and edge history
    logic [ARS_SYNC_W-1:0] s1_reg, s2_reg, s3_reg;
    logic                  busy_q_reg;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s1_reg     <= ARS_SYNC_RST;
            s2_reg     <= ARS_SYNC_RST;
            s3_reg     <= ARS_SYNC_RST;
            busy_q_reg <= 1'b0;
        end else begin
            s1_reg     <= {three_wire_i, conversion_start_n_i, dio_i, din_i, sclk_i, rd_wr_i,
                           cs_n_i};
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            busy_q_reg <= busy_i;
        end
    end

    logic tw, cs_act, rw_rise, rw_fall, sck_rise, sck_fall, cs_rise, din_sel;
    logic cv_rise, busy_fall, start_rd, start_wr;

    always_comb begin
        tw        = s2_reg[ARS_IDX_TW];
        cs_act    = tw | ~s2_reg[ARS_IDX_CSN];
        rw_rise   = s2_reg[ARS_IDX_RW] & ~s3_reg[ARS_IDX_RW];
        rw_fall   = ~s2_reg[ARS_IDX_RW] & s3_reg[ARS_IDX_RW];
        sck_rise  = s2_reg[ARS_IDX_SCK] & ~s3_reg[ARS_IDX_SCK];
        sck_fall  = ~s2_reg[ARS_IDX_SCK] & s3_reg[ARS_IDX_SCK];
        cs_rise   = ~tw & s2_reg[ARS_IDX_CSN] & ~s3_reg[ARS_IDX_CSN];
        din_sel   = tw ? s2_reg[ARS_IDX_DIO] : s2_reg[ARS_IDX_DIN];
        cv_rise   = s2_reg[ARS_IDX_CVN] & ~s3_reg[ARS_IDX_CVN];
        busy_fall = busy_q_reg & ~busy_i;
        start_rd  = rw_rise & cs_act;
        start_wr  = rw_fall & cs_act;
    end

    // serial port state
    ars_state_t              st_reg, st_next;
    logic [ARS_RES_W-1:0]    sh_reg, sh_next;
    logic [3:0]              bits_reg, bits_next;
    logic                    skip_reg, skip_next;
    logic                    doe_reg, doe_next;
    logic                    ioe_reg, ioe_next;
    logic [ARS_CTRL_W-1:0]   wsh_reg, wsh_next;
    logic [2:0]              wcnt_reg, wcnt_next;
    logic [ARS_CTRL_W-1:0]   ctrl_reg, ctrl_next;
    logic                    cval_reg, cval_next;
    logic                    pd_reg, pd_next;

    always_comb begin
        st_next   = st_reg;
        sh_next   = sh_reg;
        bits_next = bits_reg;
        skip_next = skip_reg;
        doe_next  = doe_reg;
        ioe_next  = ioe_reg;
        wsh_next  = wsh_reg;
        wcnt_next = wcnt_reg;
        ctrl_next = ctrl_reg;
        cval_next = 1'b0;
        pd_next   = pd_reg;
        if (start_rd) begin
            st_next   = ARS_ST_READ;
            sh_next   = result_i;
            bits_next = ARS_BIT_RST;
            skip_next = tw;
            doe_next  = ~tw;
            ioe_next  = tw;
        end else begin
            case (st_reg)
                ARS_ST_IDLE: begin
                    if (start_wr) begin
                        st_next   = ARS_ST_WRITE;
                        wcnt_next = 3'h0;
                    end
                end
                ARS_ST_READ: begin
                    if (rw_fall | cs_rise) begin
                        doe_next = 1'b0;
                        ioe_next = 1'b0;
                        st_next  = start_wr ? ARS_ST_WRITE : ARS_ST_IDLE;
                        wcnt_next = 3'h0;
                    end else if (sck_fall & cs_act) begin
                        if (skip_reg) begin
                            skip_next = 1'b0;
                        end else if (bits_reg != 4'(ARS_RES_W - 1)) begin
                            sh_next   = {sh_reg[ARS_RES_W-2:0], 1'b0};
                            bits_next = bits_reg + 4'h1;
                        end
                    end
                end
                ARS_ST_WRITE: begin
                    if (sck_rise & cs_act) begin
                        wsh_next  = {wsh_reg[ARS_CTRL_W-2:0], din_sel};
                        wcnt_next = wcnt_reg + 3'h1;
                        if (wcnt_reg == 3'h7) begin
                            ctrl_next = {wsh_reg[ARS_CTRL_W-2:0], din_sel};
                            cval_next = 1'b1;
                            st_next   = ARS_ST_WDONE;
                        end
                    end
                end
                ARS_ST_WDONE: begin
                    st_next = ARS_ST_WDONE;
                end
                default: begin
                    st_next  = ARS_ST_IDLE;
                    doe_next = 1'b0;
                    ioe_next = 1'b0;
                end
            endcase
        end
        if (cv_rise) begin
            pd_next = 1'b0;
        end else if (busy_fall & ~s2_reg[ARS_IDX_CVN]) begin
            pd_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_reg   <= ARS_ST_IDLE;
            sh_reg   <= '0;
            bits_reg <= ARS_BIT_RST;
            skip_reg <= 1'b0;
            doe_reg  <= 1'b0;
            ioe_reg  <= 1'b0;
            wsh_reg  <= ARS_CTRL_RST;
            wcnt_reg <= 3'h0;
            ctrl_reg <= ARS_CTRL_RST;
            cval_reg <= 1'b0;
            pd_reg   <= 1'b0;
        end else begin
            st_reg   <= st_next;
            sh_reg   <= sh_next;
            bits_reg <= bits_next;
            skip_reg <= skip_next;
            doe_reg  <= doe_next;
            ioe_reg  <= ioe_next;
            wsh_reg  <= wsh_next;
            wcnt_reg <= wcnt_next;
            ctrl_reg <= ctrl_next;
            cval_reg <= cval_next;
            pd_reg   <= pd_next;
        end
    end

    assign dout_o       = sh_reg[ARS_RES_W-1];
    assign dio_o        = sh_reg[ARS_RES_W-1];
    assign dout_oe_o    = doe_reg;
    assign dio_oe_o     = ioe_reg;
    assign ctrl_byte_o  = ctrl_reg;
    assign ctrl_valid_o = cval_reg;
    assign power_down_o = pd_reg;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    AST_RD_MSB: assert property (start_rd |=> (doe_reg ^ ioe_reg)
                                 && sh_reg == $past(result_i))
        else $error("read start did not present the msb");
    AST_RD_LANE: assert property (start_rd && tw |=> ioe_reg && !doe_reg)
        else $error("three-wire read not on shared pin");
    AST_LANES: assert property (!(doe_reg && ioe_reg))
        else $error("both data lanes enabled");
    AST_SHIFT: assert property (st_reg == ARS_ST_READ && sck_fall && cs_act
                                && !skip_reg && bits_reg < 4'h9 && !rw_fall && !cs_rise
                                && !start_rd
                                |=> sh_reg == {$past(sh_reg[ARS_RES_W-2:0]), 1'b0})
        else $error("read bit not shifted on falling clock");
    AST_SKIP: assert property (st_reg == ARS_ST_READ && skip_reg && sck_fall
                               && cs_act && !start_rd && !rw_fall |=> $stable(sh_reg))
        else $error("three-wire shifted on first falling edge");
    AST_RELEASE: assert property (st_reg == ARS_ST_READ && (rw_fall || cs_rise)
                                  && !start_rd |=> !doe_reg && !ioe_reg)
        else $error("data output not released");
    AST_CS_HIGH: assert property (!tw && s2_reg[ARS_IDX_CSN] && s3_reg[ARS_IDX_CSN]
                                  && $past(s2_reg[ARS_IDX_CSN]) |-> !doe_reg)
        else $error("dout driven with chip select high");
    AST_BITS: assert property (bits_reg <= 4'h9)
        else $error("more than ten result bits");
    AST_WR8: assert property (cval_reg |-> st_reg == ARS_ST_WDONE
                              && $past(wcnt_reg) == 3'h7)
        else $error("control byte not after eighth edge");
    AST_WR_IGN: assert property (st_reg == ARS_ST_WDONE |=> $stable(ctrl_reg))
        else $error("control byte changed after eight edges");
    AST_PD_UP: assert property (cv_rise |=> !pd_reg)
        else $error("no power-up on start rise");
    AST_PD_DN: assert property ($rose(pd_reg) |-> $past(busy_fall)
                                && !$past(s2_reg[ARS_IDX_CVN]))
        else $error("power-down without busy fall");

    COV_READ5: cover property (start_rd && !tw ##[1:600] rw_fall);
    COV_READ3: cover property (start_rd && tw ##[1:600] rw_fall);
    COV_WRITE: cover property (cval_reg);
    COV_PD:    cover property ($rose(pd_reg));
endmodule : ars_port

// File: test/ars_host.sv
module ars_host (
    input  wire logic clk_i,
    input  wire logic tw_i,
    input  wire logic dout_i,
    input  wire logic dout_oe_i,
    input  wire logic dio_dev_i,
    input  wire logic dio_oe_i,
    output logic      cs_n_o,
    output logic      rd_wr_o,
    output logic      sclk_o,
    output wire logic din_o,
    output wire logic dio_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog = 1'b0;
    logic drv = 1'b0;
    logic dat = 1'b0;
    wire  rx;
    initial begin
        cs_n_o = 1'b1;
        rd_wr_o = 1'b0;
        sclk_o = 1'b0; // still outside frames
    end
    always @(posedge clk_i) tog <= ~tog;
    // released lines show a changing pattern
    assign dio_o = dio_oe_i ? dio_dev_i : (drv ? dat : tog);
    assign din_o = drv ? dat : tog;
    assign rx = tw_i ? dio_o : (dout_oe_i ? dout_i : tog);
    task tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    // chip select, changed off the sampling edge
    task select(input logic v);
        cs_n_o = v;
    endtask : select
    // one serial clock of 125 ns, sampled at its rise
    task bit_x(input logic b, output logic r);
        dat = b;
        tick(12);
        sclk_o = 1'b1;
        r = rx;
        tick(13);
        sclk_o = 1'b0;
    endtask : bit_x
    // select low then high before each read, held high
    task read(input int n, output logic [15:0] q);
        logic r;
        q = '0;
        rd_wr_o = 1'b0;
        tick(6);
        rd_wr_o = 1'b1;
        tick(6);
        for (int i = 0; i < n; i++) begin
            bit_x(1'b0, r);
            q = {q[14:0], r};
        end
    endtask : read
    // ends by chip select rise or select fall, then quiet time
    task end_rd(input logic by_cs);
        if (by_cs) cs_n_o = 1'b1;
        else rd_wr_o = 1'b0;
        tick(21);
    endtask : end_rd
    // select high then low before each write
    task write(input logic [9:0] v, input int n);
        logic r;
        rd_wr_o = 1'b1;
        tick(6);
        rd_wr_o = 1'b0;
        drv = 1'b1;
        for (int i = 0; i < n; i++) bit_x(v[9-i], r);
        drv = 1'b0;
        tick(8);
    endtask : write
endmodule : ars_host

// File: test/ars_port_test.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t: mismatch", $time); end end
module ars_port_test;
    import ars_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_i, nrst_i, tw, conv_n, busy;
    logic [ARS_RES_W-1:0] res;
    logic                 dout, dout_oe, dio, dio_oe, cval, pd, cs_n, rd_wr, sclk;
    wire                  din, dio_w;
    logic [ARS_CTRL_W-1:0] ctrl;
    logic [15:0]          q;
    int                   mismatches = 0, check_count = 0, vcnt = 0;
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(negedge clk_i) if (cval === 1'b1) vcnt <= vcnt + 1;
    ars_port u_ars_port (.clk_i(clk_i), .nrst_i(nrst_i), .three_wire_i(tw), .cs_n_i(cs_n),
        .rd_wr_i(rd_wr), .sclk_i(sclk), .din_i(din), .dio_i(dio_w),
        .conversion_start_n_i(conv_n), .busy_i(busy), .result_i(res), .dout_o(dout),
        .dout_oe_o(dout_oe), .dio_o(dio), .dio_oe_o(dio_oe), .ctrl_byte_o(ctrl),
        .ctrl_valid_o(cval), .power_down_o(pd));
    ars_host u_ars_host (.clk_i(clk_i), .tw_i(tw), .dout_i(dout), .dout_oe_i(dout_oe),
        .dio_dev_i(dio), .dio_oe_i(dio_oe), .cs_n_o(cs_n), .rd_wr_o(rd_wr), .sclk_o(sclk),
        .din_o(din), .dio_o(dio_w));
    task close_out();
        $display("mismatches %0d check_count %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task t_read5(input logic by_cs, input int n);
        tw = 1'b0;
        u_ars_host.select(1'b0); // alone on the bus
        u_ars_host.read(n, q);
        `CHK(dout_oe, 1'b1)
        `CHK(q[9:0], (res >> (10 - n)))
        u_ars_host.end_rd(by_cs);
        `CHK(dout_oe, 1'b0)
    endtask : t_read5
    task t_cs_high();
        int v0;
        v0 = vcnt;
        u_ars_host.select(1'b1); // stays high
        u_ars_host.read(2, q);
        `CHK(dout_oe, 1'b0)
        u_ars_host.write(10'h3FF, 8);
        `CHK(vcnt, v0)
    endtask : t_cs_high
    task t_read3();
        tw = 1'b1;
        u_ars_host.read(11, q);
        `CHK(dio_oe, 1'b1)
        `CHK(dout_oe, 1'b0)
        `CHK(q[10:0], {res[9], res})
        u_ars_host.end_rd(1'b0);
        `CHK(dio_oe, 1'b0)
    endtask : t_read3
    task t_write(input logic mode, input logic [9:0] v, input int n);
        int v0;
        tw = mode;
        u_ars_host.select(1'b0); // alone on the bus
        v0 = vcnt;
        u_ars_host.write(v, n);
        `CHK(vcnt, v0 + 1)
        `CHK(ctrl, v[9:2])
    endtask : t_write
    task t_pwr();
        conv_n = 1'b0; // start pulse held low
        busy = 1'b1;
        u_ars_host.tick(3);
        busy = 1'b0;
        u_ars_host.tick(3);
        `CHK(pd, 1'b1)
        conv_n = 1'b1;
        u_ars_host.tick(6);
        `CHK(pd, 1'b0)
        busy = 1'b1;
        u_ars_host.tick(3);
        busy = 1'b0;
        u_ars_host.tick(3);
        `CHK(pd, 1'b0)
    endtask : t_pwr
    initial begin
        nrst_i = 1'b0;
        tw = 1'b0;
        conv_n = 1'b1;
        busy = 1'b0;
        res = 10'h2B5;
        repeat (6) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        `CHK(ctrl, ARS_CTRL_RST)
        `CHK(dout_oe, 1'b0)
        `CHK(pd, 1'b0)
        t_read5(1'b0, 10);
        res = 10'h14A;
        t_read5(1'b1, 8);
        t_cs_high();
        t_write(1'b0, 10'h2D3, 10);
        t_write(1'b0, 10'h0A4, 8);
        t_read3();
        t_write(1'b1, 10'h1E7, 10);
        t_pwr();
        close_out();
    end
    initial begin
        #100us;
        mismatches++;
        close_out();
    end
endmodule : ars_port_test
